// ==== core/sac_map.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SAC_OFF_SEL 2'h0
`define SAC_OFF_CTL 2'h1
`define SAC_OFF_LOW 2'h2
`define SAC_OFF_HIGH 2'h3
// ----------------------------------------
// Control register field positions
// ----------------------------------------
`define SAC_CTL_EN 7
`define SAC_CTL_START 6
`define SAC_CTL_FREE 5
`define SAC_CTL_FLAG 4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SAC_SEL_RST 8'h00
`define SAC_DIV_RST 3'h0
// ----------------------------------------
// Timing in converter clock cycles, and the lowest differential channel code
// ----------------------------------------
`define SAC_LEN_NORMAL 5'h0d
`define SAC_LEN_SYNC 5'h0e
`define SAC_LEN_FIRST 5'h19
`define SAC_SH_BACK 5'h0c
`define SAC_DIFF_BASE 5'h08
`endif

// ==== core/sac_pkg.sv ====
// Types shared by the converter sequencer.
`default_nettype none
package sac_pkg;
    // Selection word written by software and buffered.
    typedef struct packed {
        logic [1:0] reference_select;
        logic result_left_align;
        logic [4:0] channel_gain_select;
    } sac_sel_t;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_CONV = 2'b01
    } sac_state_t;
endpackage : sac_pkg
`default_nettype wire

// ==== core/sac_sequencer.sv ====
// Successive approximation converter sequencer with its registers.
// ----------------------------------------
// Operation
// RULE_01: Ten-bit result by successive approximation.
// RULE_02: Selections apply only while enabled.
// RULE_03: Right-aligned default, left when bit set.
// RULE_04: Low byte read locks result updates.
// RULE_05: High byte read releases the lock.
// RULE_06: Done flag rises even when locked.
// RULE_07: Start bit stays set until done.
// RULE_08: Channel change waits for conversion end.
// RULE_09: Free run needs a first start.
// RULE_10: Free run ignores the done flag.
// RULE_11: Prescaler held reset while disabled.
// RULE_12: Start waits for next converter clock.
// RULE_13: Thirteen cycles, twenty-five when first.
// RULE_14: Sample at 1.5 or 13.5 cycles. 14-cycle conversions sample at 2.5 here.
// RULE_15: Completion writes result, flags, clears start.
// RULE_16: Free run restarts at once.
// RULE_17: Differential sampling tied to half-rate clock.
// RULE_18: User differential: 13 or 14 cycles.
// RULE_19: Auto differential conversions take 14 cycles.
// RULE_20: Differential via amplifier, single-ended bypasses.
// RULE_21: Reference select picks reference source.
// RULE_22: Software keeps converter clock in range.
// RULE_23: Selection buffer frozen during conversion.
// RULE_24: Fixed bit placement per alignment.
// RULE_25: Prescaler divides by powers of two.
// ----------------------------------------
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"

module sac_sequencer #(
    // Prescaler width; the widest ratio is two to this power.
    parameter int unsigned PRE_W = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic cmp_in,
    output logic [9:0] dac_code,
    output logic sample_hold,
    output logic analog_on,
    output logic [4:0] chan_sel,
    output logic [1:0] ref_sel,
    output logic amp_bypass,
    output logic conv_busy,
    output logic done_pulse
);

    // ----------------------------------------
    // State
    // ----------------------------------------

    // Software selection and its frozen copy.
    sac_pkg::sac_sel_t sel_reg;
    sac_pkg::sac_sel_t buf_reg;

    // Control bits.
    logic enable_reg;
    logic start_reg;
    logic free_reg;
    logic flag_reg;
    logic [2:0] div_reg;

    // Result and read lock.
    logic [9:0] res_reg;
    logic lock_reg;

    // First conversion after enable is pending.
    logic first_reg;

    // Half-rate sync clock level.
    logic half_reg;

    // Prescaler counter.
    logic [PRE_W-1:0] pre_reg;

    // Sequencer.
    sac_pkg::sac_state_t state_reg;
    logic [4:0] cnt_reg;
    logic [4:0] len_reg;

    // Approximation loop.
    logic [9:0] trial_reg;
    logic [3:0] pos_reg;
    logic run_reg;
    logic sh_reg;
    logic done_reg;

    // Read data register.
    logic [7:0] rdata_reg;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------

    // Strobes qualified by address.
    wire logic wr_sel = bus_wr & (bus_addr == `SAC_OFF_SEL);
    wire logic wr_ctl = bus_wr & (bus_addr == `SAC_OFF_CTL);
    wire logic rd_low = bus_rd & (bus_addr == `SAC_OFF_LOW);
    wire logic rd_high = bus_rd & (bus_addr == `SAC_OFF_HIGH);

    // Write data fields of the control register.
    wire logic w_en = bus_wdata[`SAC_CTL_EN];
    wire logic w_start = bus_wdata[`SAC_CTL_START];
    wire logic w_flag = bus_wdata[`SAC_CTL_FLAG];

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------

    // Ratio codes zero and one both divide by two.
    wire logic [2:0] ratio_sel = (div_reg == 3'h0) ? 3'h1 : div_reg;

    // Low bits that must be ones for a rising edge.
    wire logic [7:0] mask8 = (8'h01 << ratio_sel) - 8'h01; // RULE_25
    wire logic [PRE_W-1:0] pre_mask = PRE_W'(mask8);
    wire logic [PRE_W-1:0] pre_lo = pre_reg & pre_mask;

    // Rising and falling edges of the converter clock.
    wire logic tick_rise = enable_reg & (pre_lo == pre_mask);
    wire logic tick_fall = enable_reg & (pre_lo == (pre_mask >> 1));

    // ----------------------------------------
    // Sequencer decode
    // ----------------------------------------

    wire logic idle = (state_reg == sac_pkg::SAC_IDLE);
    wire logic busy = (state_reg == sac_pkg::SAC_CONV);

    // Differential codes sit above the single-ended block.
    wire logic sel_diff =
        (sel_reg.channel_gain_select >= `SAC_DIFF_BASE);
    wire logic buf_diff =
        (buf_reg.channel_gain_select >= `SAC_DIFF_BASE);

    // A user start waits for a converter clock rising edge.
    wire logic go_user = idle & start_reg & tick_rise; // RULE_12

    // Length of a user-started conversion.
    wire logic [4:0] len_user =
        first_reg ? `SAC_LEN_FIRST : // RULE_13
        (sel_diff & half_reg) ? `SAC_LEN_SYNC : // RULE_18
        `SAC_LEN_NORMAL;

    // Automatic restarts in free run.
    wire logic [4:0] len_auto =
        buf_diff ? `SAC_LEN_SYNC : `SAC_LEN_NORMAL; // RULE_19

    // Last cycle and completion edge.
    wire logic last_cyc = busy & (cnt_reg == len_reg - 5'h01);
    wire logic done_w = last_cyc & tick_rise;

    // Sample point is always eleven and a half cycles before the end.
    wire logic [4:0] sh_cyc = len_reg - `SAC_SH_BACK;
    wire logic sh_w = busy & tick_fall & (cnt_reg == sh_cyc); // RULE_14

    // Free run keeps going whatever the flag says.
    wire logic go_auto = done_w & free_reg; // RULE_10 RULE_16

    // ----------------------------------------
    // Approximation step
    // ----------------------------------------

    // Bit under trial and the one below it.
    wire logic [9:0] bit_cur = 10'h001 << pos_reg;
    wire logic [9:0] bit_low = bit_cur >> 1;

    // Keep the trial bit when the input is above the code.
    wire logic [9:0] trial_next =
        (cmp_in ? trial_reg : (trial_reg & ~bit_cur)) | bit_low; // RULE_01

    wire logic step_w = run_reg & tick_rise;

    // ----------------------------------------
    // Result placement
    // ----------------------------------------

    // A read of the low byte counts as locked at once.
    wire logic lock_eff = lock_reg | rd_low; // RULE_04
    wire logic res_wr = done_w & ~lock_eff; // RULE_04

    wire logic left = sel_reg.result_left_align;

    // Right-aligned leaves six zero bits on top.
    wire logic [7:0] low_byte = left ?
        {res_reg[1:0], 6'h00} : res_reg[7:0]; // RULE_03 RULE_24
    wire logic [7:0] high_byte = left ?
        res_reg[9:2] : {6'h00, res_reg[9:8]}; // RULE_03 RULE_24

    // Control register read view; bit 3 reads zero.
    wire logic [7:0] ctl_view = {enable_reg, start_reg, free_reg,
        flag_reg, 1'b0, div_reg};

    // Read mux; every offset is mapped.
    wire logic [7:0] rd_mux =
        (bus_addr == `SAC_OFF_SEL) ? sel_reg :
        (bus_addr == `SAC_OFF_CTL) ? ctl_view :
        (bus_addr == `SAC_OFF_LOW) ? low_byte : high_byte;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------

    // Selection and control fields written by software.
    always_ff @(posedge clk) begin
        if (reset) begin
            sel_reg <= `SAC_SEL_RST;
            enable_reg <= 1'b0;
            free_reg <= 1'b0;
            div_reg <= `SAC_DIV_RST;
        end else if (ce) begin
            if (wr_sel) begin
                sel_reg <= bus_wdata;
            end
            if (wr_ctl) begin
                enable_reg <= w_en;
                free_reg <= bus_wdata[`SAC_CTL_FREE]; // RULE_09
                div_reg <= bus_wdata[2:0];
            end
        end
    end

    // Start bit: set by software, cleared by a completion outside free run.
    // Disabling drops it, since the conversion is abandoned.
    always_ff @(posedge clk) begin
        if (reset) begin
            start_reg <= 1'b0;
        end else if (ce) begin
            if (wr_ctl & w_en & w_start) begin
                start_reg <= 1'b1; // RULE_07 RULE_09
            end else if (~enable_reg) begin
                start_reg <= 1'b0;
            end else if (done_w & ~free_reg) begin
                start_reg <= 1'b0; // RULE_07 RULE_15
            end
        end
    end

    // Done flag: a completion beats a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_reg <= 1'b0;
        end else if (ce) begin
            if (done_w) begin
                flag_reg <= 1'b1; // RULE_06 RULE_15
            end else if (wr_ctl & w_flag) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Result and lock
    // ----------------------------------------

    // Lock is set by a low read and freed by a high read.
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_reg <= 1'b0;
        end else if (ce) begin
            if (rd_low) begin
                lock_reg <= 1'b1; // RULE_04
            end else if (rd_high) begin
                lock_reg <= 1'b0; // RULE_05
            end
        end
    end

    // Result store; a locked completion is dropped.
    always_ff @(posedge clk) begin
        if (reset) begin
            res_reg <= 10'h000;
        end else if (ce & res_wr) begin
            res_reg <= trial_reg; // RULE_15
        end
    end

    // Read data stands the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 8'h00;
        end else if (ce & bus_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    // ----------------------------------------
    // Prescaler and half-rate clock
    // ----------------------------------------

    // Both stay cleared while disabled, so the first edge
    // after enabling always comes a full ratio later.
    always_ff @(posedge clk) begin
        if (reset) begin
            pre_reg <= '0;
            half_reg <= 1'b0;
        end else if (ce) begin
            if (~enable_reg) begin
                pre_reg <= '0; // RULE_11
                half_reg <= 1'b0;
            end else begin
                pre_reg <= pre_reg + 1'b1; // RULE_11
                if (tick_rise) begin
                    half_reg <= ~half_reg; // RULE_17
                end
            end
        end
    end

    // First conversion marker re-arms whenever disabled.
    always_ff @(posedge clk) begin
        if (reset) begin
            first_reg <= 1'b1;
        end else if (ce) begin
            if (~enable_reg) begin
                first_reg <= 1'b1; // RULE_13
            end else if (done_w) begin
                first_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Selection buffer
    // ----------------------------------------

    // Follows software only when enabled and not mid-conversion.
    // Reopening in the last cycle lets free run pick up a new
    // channel for the conversion that follows at once.
    always_ff @(posedge clk) begin
        if (reset) begin
            buf_reg <= `SAC_SEL_RST;
        end else if (ce) begin
            if (enable_reg & (idle | last_cyc)) begin
                buf_reg <= sel_reg; // RULE_02 RULE_08 RULE_23
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------

    // Counts converter clock cycles of one conversion.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= sac_pkg::SAC_IDLE;
            cnt_reg <= 5'h00;
            len_reg <= `SAC_LEN_NORMAL;
        end else if (ce) begin
            case (state_reg)
                sac_pkg::SAC_IDLE: begin
                    if (go_user) begin
                        state_reg <= sac_pkg::SAC_CONV;
                        cnt_reg <= 5'h00;
                        len_reg <= len_user; // RULE_13 RULE_18
                    end
                end
                sac_pkg::SAC_CONV: begin
                    if (~enable_reg) begin
                        state_reg <= sac_pkg::SAC_IDLE;
                    end else if (go_auto) begin
                        cnt_reg <= 5'h00; // RULE_16
                        len_reg <= len_auto; // RULE_19
                    end else if (done_w) begin
                        state_reg <= sac_pkg::SAC_IDLE; // RULE_15
                    end else if (tick_rise) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Sample and approximation loop
    // ----------------------------------------

    // Sampling opens the loop at the top bit; each rising edge
    // decides one bit, so ten bits finish before the end.
    always_ff @(posedge clk) begin
        if (reset) begin
            trial_reg <= 10'h000;
            pos_reg <= 4'h0;
            run_reg <= 1'b0;
        end else if (ce) begin
            if (~enable_reg) begin
                run_reg <= 1'b0;
            end else if (sh_w) begin
                trial_reg <= 10'h200; // RULE_01
                pos_reg <= 4'h9;
                run_reg <= 1'b1;
            end else if (step_w) begin
                trial_reg <= trial_next; // RULE_01
                pos_reg <= pos_reg - 4'h1;
                if (pos_reg == 4'h0) begin
                    run_reg <= 1'b0;
                end
            end
        end
    end

    // One-cycle sample and completion pulses.
    always_ff @(posedge clk) begin
        if (reset) begin
            sh_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce) begin
            sh_reg <= sh_w;
            done_reg <= done_w;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    assign bus_rdata = rdata_reg;
    assign dac_code = trial_reg;
    assign sample_hold = sh_reg;
    assign analog_on = enable_reg;
    assign chan_sel = buf_reg.channel_gain_select; // RULE_20
    assign ref_sel = buf_reg.reference_select; // RULE_21
    assign amp_bypass = ~buf_diff; // RULE_20
    assign conv_busy = busy;
    assign done_pulse = done_reg;

endmodule : sac_sequencer
`default_nettype wire

// ==== tb/sac_sequencer_sva.sv ====
// Port-level assertions for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module sac_sequencer_sva #(
    parameter int unsigned PRE_W = 7
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic cmp_in,
    input wire logic [9:0] dac_code,
    input wire logic sample_hold,
    input wire logic analog_on,
    input wire logic [4:0] chan_sel,
    input wire logic [1:0] ref_sel,
    input wire logic amp_bypass,
    input wire logic conv_busy,
    input wire logic done_pulse
);
    // A frozen clock enable stalls every flop, so checks pause with it.
    default clocking @(posedge clk); endclocking
    default disable iff (reset || !ce);
    // ----
    // Assertions
    // ----
    chk_done_one_cycle: assert property (done_pulse |=> !done_pulse)
        else $error("done pulse longer than one cycle");
    chk_done_after_busy: assert property (
        done_pulse |-> $past(conv_busy, 2))
        else $error("done pulse without a conversion");
    chk_sample_spacing: assert property (
        sample_hold |=> !sample_hold [*8])
        else $error("sample pulses too close");
    chk_sample_in_conv: assert property (sample_hold |-> conv_busy)
        else $error("sample outside a conversion");
    chk_chan_frozen: assert property (
        $rose(conv_busy) |=> $stable(chan_sel) [*8])
        else $error("channel moved during conversion");
    chk_ref_frozen: assert property (
        $rose(conv_busy) |=> $stable(ref_sel) [*8])
        else $error("reference moved during conversion");
    chk_amp_route: assert property (
        $stable(chan_sel) |-> amp_bypass == (chan_sel < 5'h08))
        else $error("amplifier bypass disagrees with channel");
    chk_off_idle: assert property (!analog_on [*2] |-> !conv_busy)
        else $error("converting while disabled");
    chk_enable_on: assert property (
        bus_wr && bus_addr == 2'h1 && bus_wdata[7] |-> ##[1:2] analog_on)
        else $error("enable write did not power up");
    chk_start_reads_one: assert property (
        bus_rd && bus_addr == 2'h1 && conv_busy |=> bus_rdata[6])
        else $error("start bit low during conversion");
    cover property ($rose(conv_busy));
    cover property (done_pulse && conv_busy);
    cover property (sample_hold);
endmodule : sac_sequencer_sva

bind sac_sequencer sac_sequencer_sva #(.PRE_W(PRE_W)) u_sva (.clk, .reset,
    .ce, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .cmp_in,
    .dac_code, .sample_hold, .analog_on, .chan_sel, .ref_sel, .amp_bypass,
    .conv_busy, .done_pulse);
`default_nettype wire

// ==== tb/tb_sac_sequencer.sv ====
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"
module tb_sac_sequencer;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [1:0] bus_addr = 2'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic cmp_in = 1'b0;
    logic [7:0] bus_rdata;
    logic [9:0] dac_code;
    logic sample_hold, analog_on, amp_bypass, conv_busy, done_pulse;
    logic [4:0] chan_sel;
    logic [1:0] ref_sel;
    logic [9:0] ain = 10'h000; // Analog level behind the comparator.
    int n_mismatch = 0;
    int num_checks = 0;
    int n, sh, sh_first, k;

    sac_sequencer #(.PRE_W(7)) dut (.clk, .reset, .ce, .bus_addr, .bus_wdata,
        .bus_wr, .bus_rd, .bus_rdata, .cmp_in, .dac_code, .sample_hold,
        .analog_on, .chan_sel, .ref_sel, .amp_bypass, .conv_busy, .done_pulse);

    always #4 clk = ~clk;

    // Ideal comparator; its one-clock lag is hidden only at ratios of four
    // and more, so conversion results are checked at those ratios alone.
    always @(posedge clk) cmp_in <= (ain >= dac_code);

    // ----
    // Bus and measurement tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask : rdc

    // Clocks from busy rising to the done pulse, noting the sample instant.
    task automatic conv_len(output int len, output int s);
        len = 0;
        s = -1;
        #1;
        while (conv_busy !== 1'b1 && len < 400) begin
            @(posedge clk);
            #1 len++;
        end
        len = 0;
        do begin
            @(posedge clk);
            #1 len++;
            if (sample_hold === 1'b1) s = len;
        end while (done_pulse !== 1'b1 && len < 2000);
    endtask : conv_len

    // Single conversion; a selection written mid-way must wait for the end.
    task automatic run_conv(input logic [7:0] ctl, input logic [7:0] sel,
                            output int len, output int s);
        logic [4:0] old;
        old = chan_sel;
        wr(`SAC_OFF_CTL, ctl);
        fork
            conv_len(len, s);
            begin
                repeat (20) @(posedge clk);
                rdc(`SAC_OFF_CTL, ctl);
                wr(`SAC_OFF_SEL, sel);
                repeat (4) @(posedge clk);
                #1 chk(chan_sel, old);
            end
        join
        rdc(`SAC_OFF_CTL, ctl & 8'hbf | 8'h10);
        chk(chan_sel, sel[4:0]);
        wr(`SAC_OFF_CTL, ctl & 8'hbf | 8'h10);
    endtask : run_conv

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // Hang guard, well beyond the expected run of a few thousand clocks.
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        end_sim;
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wr(`SAC_OFF_SEL, 8'h45);
        repeat (3) @(posedge clk);
        #1 chk(chan_sel, 5'h00);
        chk(ref_sel, 2'h0);
        wr(`SAC_OFF_CTL, 8'h82);
        repeat (3) @(posedge clk);
        #1 chk(chan_sel, 5'h05);
        chk(ref_sel, 2'h1);
        chk(amp_bypass, 1'b1);
        ain = 10'h2a5;
        run_conv(8'hc2, 8'h45, n, sh_first);
        chk(n, 100);
        rdc(`SAC_OFF_LOW, 8'ha5);
        rdc(`SAC_OFF_HIGH, 8'h02);
        wr(`SAC_OFF_SEL, 8'h65);
        rdc(`SAC_OFF_LOW, 8'h40);
        rdc(`SAC_OFF_HIGH, 8'ha9);
        ain = 10'h1c3;
        run_conv(8'hc2, 8'h63, n, sh);
        chk(n, 52);
        chk(sh_first - sh, 48);
        // A low-byte read holds the result until the high byte is read.
        rdc(`SAC_OFF_LOW, 8'hc0);
        ain = 10'h07e;
        run_conv(8'hc2, 8'h63, n, sh);
        rdc(`SAC_OFF_HIGH, 8'h70);
        run_conv(8'hc2, 8'h63, n, sh);
        rdc(`SAC_OFF_LOW, 8'h80);
        rdc(`SAC_OFF_HIGH, 8'h1f);
        // Every divider code: ratio two to the code, never below two.
        // At this system clock even the widest ratio runs the converter
        // clock above the full-resolution range; the ideal comparator
        // makes that harmless here, but real silicon would lose bits.
        for (k = 0; k < 8; k++) begin
            wr(`SAC_OFF_CTL, 8'hc0 | k[7:0]);
            conv_len(n, sh);
            chk(n, 13 << (k < 1 ? 1 : k));
            wr(`SAC_OFF_CTL, 8'h90 | k[7:0]);
        end
        wr(`SAC_OFF_CTL, 8'h82);
        wr(`SAC_OFF_SEL, 8'h6a);
        repeat (3) @(posedge clk);
        #1 chk(amp_bypass, 1'b0);
        for (k = 0; k < 4; k++) begin
            repeat (k) @(posedge clk);
            run_conv(8'hc2, 8'h6a, n, sh);
            // After a completion the half-rate clock phase at the next
            // start follows from how many converter edges the gap spans.
            if (k == 0) begin
                chk(n == 52 || n == 56, 1'b1);
            end else begin
                chk(n, (k == 1) ? 56 : 52);
            end
        end
        // Free run needs a start, then restarts without flag service.
        wr(`SAC_OFF_CTL, 8'ha2);
        repeat (40) @(posedge clk);
        #1 chk(conv_busy, 1'b0);
        wr(`SAC_OFF_CTL, 8'he2);
        conv_len(n, sh);
        conv_len(n, sh);
        chk(n, 56);
        conv_len(n, sh);
        chk(n, 56);
        rdc(`SAC_OFF_CTL, 8'hf2);
        wr(`SAC_OFF_SEL, 8'h63);
        repeat (3) conv_len(n, sh);
        chk(n, 52);
        wr(`SAC_OFF_CTL, 8'h92);
        conv_len(n, sh);
        rdc(`SAC_OFF_CTL, 8'h92);
        repeat (60) @(posedge clk);
        #1 chk(conv_busy, 1'b0);
        // A low clock enable freezes every flop, so the conversion is
        // stretched by exactly the frozen clocks and its result survives.
        wr(`SAC_OFF_CTL, 8'hd2);
        fork
            conv_len(n, sh);
            begin
                repeat (12) @(posedge clk);
                ce <= 1'b0;
                repeat (10) @(posedge clk);
                ce <= 1'b1;
            end
        join
        chk(n, 62);
        rdc(`SAC_OFF_HIGH, 8'h1f);
        // Disabling mid-way aborts; the next enable gives a long first one.
        wr(`SAC_OFF_CTL, 8'h92);
        wr(`SAC_OFF_CTL, 8'hc2);
        repeat (20) @(posedge clk);
        wr(`SAC_OFF_CTL, 8'h02);
        repeat (3) @(posedge clk);
        #1 chk(conv_busy, 1'b0);
        chk(analog_on, 1'b0);
        rdc(`SAC_OFF_CTL, 8'h02);
        wr(`SAC_OFF_CTL, 8'h82);
        repeat (3) @(posedge clk);
        run_conv(8'hc2, 8'h63, n, sh);
        chk(n, 100);
        end_sim;
    end
endmodule : tb_sac_sequencer
`default_nettype wire
